// ### core/rsi_init.sv
/*
  Reset state initializer: decodes reset and wake events, loads the PC,
  core status, reset-cause flags and interrupt flags; APB register slave.
  Assumes core signals on pclk, power and clear pins asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_init (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              por_req,
  input  wire logic              brownout_req,
  input  wire logic              external_clear_pin_n,
  input  wire logic              watchdog_expire,
  input  wire logic              wake_irq,
  input  wire logic              core_sleeping,
  input  wire logic              instr_retire,
  input  wire rsi_pkg::rsi_wake_t wake_src,
  input  wire logic [12:0]       pc_in,
  output logic      [12:0]       pc_value,
  output logic                   pc_load,
  output logic      [7:0]        core_status,
  output logic      [7:0]        core_int_ctrl,
  output logic                   irq
);
  import rsi_pkg::*;

  logic            por_s;
  logic            brn_s;
  logic            clr_s_n;
  logic            por_d_reg;
  logic            brn_d_reg;
  logic            clr_d_reg;
  rsi_evt_t        ev;
  logic [7:0]      status_reg;
  logic [1:0]      rcf_reg;
  logic [12:0]     pc_reg;
  logic            vec_pend_reg;
  logic [EV_W-1:0] evst_reg;
  logic [EV_W-1:0] evmsk_reg;
  logic [7:0]      cictl_v;
  logic [7:0]      pflg1_v;
  logic [7:0]      pflg2_v;
  logic            setup;
  logic            wr_acc;
  logic            any_ev;
  logic            cat_por;
  logic            cat_clr;
  logic            cat_wake;
  logic [31:0]     rd_mux;
  logic            hit;

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  rsi_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({external_clear_pin_n, brownout_req, por_req}),
    .dout    ({clr_s_n, brn_s, por_s})
  );

  // Delayed copies of the synchronised levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_d_reg <= 1'b0;
      brn_d_reg <= 1'b0;
      clr_d_reg <= 1'b1;
    end else begin
      por_d_reg <= por_s;
      brn_d_reg <= brn_s;
      clr_d_reg <= clr_s_n;
    end
  end

  // ****************************************
  // Event decode
  // ****************************************
  // Priority: a supply fault outranks anything else in flight
  always_comb begin
    ev = '0;
    if (por_s && !por_d_reg) begin
      ev.por = 1'b1;
    end else if (brn_s && !brn_d_reg) begin
      ev.brn = 1'b1;
    end else if (!clr_s_n && clr_d_reg) begin
      ev.clr_slp = core_sleeping;
      ev.clr_run = !core_sleeping;
    end else if (watchdog_expire) begin
      ev.wdog_wake = core_sleeping;
      ev.wdog_rst  = !core_sleeping;
    end else if (wake_irq && core_sleeping) begin
      ev.irq_wake = 1'b1;
    end
  end

  assign any_ev   = |ev;
  assign cat_por  = ev.por | ev.brn;
  assign cat_clr  = ev.clr_run | ev.clr_slp | ev.wdog_rst;
  assign cat_wake = ev.wdog_wake | ev.irq_wake;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !any_ev;
  // Read data is captured in setup, so access never waits
  assign pready = 1'b1;

  // Address decode with unused bits forced to zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    unique case (paddr)
      ADR_STATUS: rd_mux[7:0]      = status_reg;
      ADR_CICTL:  rd_mux[7:0]      = cictl_v;
      ADR_PFLG1:  rd_mux[7:0]      = pflg1_v;
      ADR_PFLG2:  rd_mux[7:0]      = pflg2_v;
      ADR_RCF:    rd_mux[1:0]      = rcf_reg;
      ADR_EVST:   rd_mux[EV_W-1:0] = evst_reg;
      ADR_EVMSK:  rd_mux[EV_W-1:0] = evmsk_reg;
      ADR_PCRD:   rd_mux[12:0]     = pc_reg;
      default:    hit              = 1'b0;
    endcase
  end

  // Registered read data and error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !hit;
    end
  end

  // ****************************************
  // Core status register
  // ****************************************
  // Timeout and powerdown are read-only to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= STATUS_RST;
    end else if (cat_por) begin
      status_reg <= {3'b000, 2'b11, status_reg[2:0]};
    end else if (ev.clr_run) begin
      status_reg <= {3'b000, status_reg[4:0]};
    end else if (ev.clr_slp) begin
      status_reg <= {3'b000, 2'b10, status_reg[2:0]};
    end else if (ev.wdog_rst) begin
      status_reg <= {4'b0000, status_reg[3:0]};
    end else if (ev.wdog_wake) begin
      status_reg <= {status_reg[7:5], 2'b00, status_reg[2:0]};
    end else if (ev.irq_wake) begin
      status_reg <= {status_reg[7:5], 2'b10, status_reg[2:0]};
    end else if (wr_acc && paddr == ADR_STATUS) begin
      status_reg <= {pwdata[7:5], status_reg[ST_TMO], status_reg[ST_PWD], pwdata[2:0]};
    end
  end

  // ****************************************
  // Reset-cause flags
  // ****************************************
  // Events beat a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcf_reg <= RCF_RST;
    end else if (ev.por) begin
      rcf_reg[RCF_PWR] <= 1'b0;
    end else if (ev.brn) begin
      rcf_reg[RCF_BRN] <= 1'b0;
    end else if (wr_acc && paddr == ADR_RCF) begin
      rcf_reg <= pwdata[1:0];
    end
  end

  // ****************************************
  // Program counter load
  // ****************************************
  // Vector waits for the instruction after the wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg       <= PC_RESET;
      pc_load      <= 1'b0;
      vec_pend_reg <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (cat_por || cat_clr) begin
        pc_reg       <= PC_RESET;
        pc_load      <= 1'b1;
        vec_pend_reg <= 1'b0;
      end else if (cat_wake) begin
        pc_reg       <= pc_in + 13'h0001;
        pc_load      <= 1'b1;
        vec_pend_reg <= ev.irq_wake && cictl_v[IC_GLB_EN];
      end else if (vec_pend_reg && instr_retire) begin
        pc_reg       <= PC_VECTOR;
        pc_load      <= 1'b1;
        vec_pend_reg <= 1'b0;
      end
    end
  end

  assign pc_value      = pc_reg;
  assign core_status   = status_reg;
  assign core_int_ctrl = cictl_v;

  // ****************************************
  // Interrupt flag registers
  // ****************************************
  rsi_pat_reg #(
    .IMPL(8'hff), .POR_MSK(IC_POR_MSK), .POR_VAL(IC_POR_VAL),
    .CLR_MSK(IC_POR_MSK), .CLR_VAL(IC_POR_VAL)
  ) u_cictl (
    .pclk     (pclk),
    .presetn  (presetn),
    .por_evt  (cat_por),
    .clr_evt  (cat_clr),
    .wake_evt (cat_wake),
    .wake_set (wake_src.cictl),
    .wr_en    (wr_acc && paddr == ADR_CICTL),
    .wr_data  (pwdata[7:0]),
    .value    (cictl_v)
  );

  rsi_pat_reg #(
    .IMPL(8'hff), .POR_MSK(PF1_MSK), .POR_VAL(PF1_VAL),
    .CLR_MSK(PF1_MSK), .CLR_VAL(PF1_VAL)
  ) u_pflg1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .por_evt  (cat_por),
    .clr_evt  (cat_clr),
    .wake_evt (cat_wake),
    .wake_set (wake_src.pflg1),
    .wr_en    (wr_acc && paddr == ADR_PFLG1),
    .wr_data  (pwdata[7:0]),
    .value    (pflg1_v)
  );

  // Only one flag bit is built here; the rest read zero
  rsi_pat_reg #(
    .IMPL(PF2_IMPL), .POR_MSK(PF2_IMPL), .POR_VAL(PF2_VAL),
    .CLR_MSK(PF2_IMPL), .CLR_VAL(PF2_VAL)
  ) u_pflg2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .por_evt  (cat_por),
    .clr_evt  (cat_clr),
    .wake_evt (cat_wake),
    .wake_set (wake_src.pflg2),
    .wr_en    (wr_acc && paddr == ADR_PFLG2),
    .wr_data  (pwdata[7:0]),
    .value    (pflg2_v)
  );

  // ****************************************
  // Event status, mask and interrupt
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evst_reg <= '0;
    end else if (psel && penable && pwrite && paddr == ADR_EVST) begin
      evst_reg <= (evst_reg & ~pwdata[EV_W-1:0]) | ev;
    end else begin
      evst_reg <= evst_reg | ev;
    end
  end

  // Mask register, one enable per event bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evmsk_reg <= '0;
    end else if (psel && penable && pwrite && paddr == ADR_EVMSK) begin
      evmsk_reg <= pwdata[EV_W-1:0];
    end
  end

  assign irq = |(evst_reg & evmsk_reg);

  // ****************************************
  // Assertions
  // ****************************************
  a_por_status: assert property (@(posedge pclk) disable iff (!presetn)
    ev.por |=> status_reg[7:3] == 5'b00011 && pc_reg == 13'h0000)
    else $error("power-on status or pc wrong");

  a_por_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ev.por |=> rcf_reg[1] == 1'b0 && rcf_reg[0] == $past(rcf_reg[0]))
    else $error("power flag not cleared alone");

  a_clr_bank: assert property (@(posedge pclk) disable iff (!presetn)
    ev.clr_run |=> status_reg[7:5] == 3'b000
      && status_reg[4:0] == $past(status_reg[4:0]) && rcf_reg == $past(rcf_reg))
    else $error("running clear wrong");

  a_clr_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    ev.clr_slp |=> status_reg[7:3] == 5'b00010 && pc_load)
    else $error("sleeping clear wrong");

  a_wdog_reset: assert property (@(posedge pclk) disable iff (!presetn)
    ev.wdog_rst |=> status_reg[7:4] == 4'b0000 && rcf_reg == $past(rcf_reg))
    else $error("watchdog reset wrong");

  a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
    cat_wake |=> pc_reg == $past(pc_in) + 13'h0001
      && status_reg[4:3] == ($past(ev.irq_wake) ? 2'b10 : 2'b00))
    else $error("wake resume wrong");

  a_brn_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ev.brn |=> rcf_reg[0] == 1'b0 && rcf_reg[1] == $past(rcf_reg[1]))
    else $error("brownout flag wrong");

  a_vector_load: assert property (@(posedge pclk) disable iff (!presetn)
    vec_pend_reg && instr_retire && !any_ev |=> pc_reg == 13'h0004 && pc_load)
    else $error("vector not loaded");

  a_wake_flags: assert property (@(posedge pclk) disable iff (!presetn)
    cat_wake |=> (pflg1_v & $past(wake_src.pflg1)) == $past(wake_src.pflg1))
    else $error("wake source not recorded");

  a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $past(setup && paddr == ADR_RCF) |-> prdata[31:2] == 30'h0)
    else $error("unused bits not zero");

  a_pat_por: assert property (@(posedge pclk) disable iff (!presetn)
    cat_por |=> pflg1_v == 8'h00 && cictl_v[7:1] == 7'h00)
    else $error("flag reset pattern wrong");

endmodule : rsi_init
`default_nettype wire

// ### core/rsi_pkg.sv
/*
  Constants, register map and carrier types of the reset state initializer.
  Assumes one 125 MHz clock domain and an APB master with 12-bit byte addresses.
*/
package rsi_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [9:0]  IDX_STATUS = 10'h003;
  localparam logic [9:0]  IDX_CICTL  = 10'h00b;
  localparam logic [9:0]  IDX_PFLG1  = 10'h00c;
  localparam logic [9:0]  IDX_PFLG2  = 10'h00d;
  localparam logic [9:0]  IDX_RCF    = 10'h08e;
  localparam logic [9:0]  IDX_EVST   = 10'h040;
  localparam logic [9:0]  IDX_EVMSK  = 10'h041;
  localparam logic [9:0]  IDX_PCRD   = 10'h042;
  localparam logic [11:0] ADR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADR_CICTL  = {IDX_CICTL, 2'b00};
  localparam logic [11:0] ADR_PFLG1  = {IDX_PFLG1, 2'b00};
  localparam logic [11:0] ADR_PFLG2  = {IDX_PFLG2, 2'b00};
  localparam logic [11:0] ADR_RCF    = {IDX_RCF, 2'b00};
  localparam logic [11:0] ADR_EVST   = {IDX_EVST, 2'b00};
  localparam logic [11:0] ADR_EVMSK  = {IDX_EVMSK, 2'b00};
  localparam logic [11:0] ADR_PCRD   = {IDX_PCRD, 2'b00};

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          ST_TMO     = 4;
  localparam int          ST_PWD     = 3;
  localparam int          RCF_PWR    = 1;
  localparam int          RCF_BRN    = 0;
  localparam int          IC_GLB_EN  = 7;
  localparam int          PC_W       = 13;
  localparam int          EV_W       = 7;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [1:0]  RCF_RST    = 2'h0;
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [12:0] PC_VECTOR  = 13'h0004;

  // Per-category patterns for the interrupt flag registers
  localparam logic [7:0]  IC_POR_MSK = 8'hfe;
  localparam logic [7:0]  IC_POR_VAL = 8'h00;
  localparam logic [7:0]  PF1_MSK    = 8'hff;
  localparam logic [7:0]  PF1_VAL    = 8'h00;
  localparam logic [7:0]  PF2_IMPL   = 8'h01;
  localparam logic [7:0]  PF2_VAL    = 8'h00;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic irq_wake;
    logic wdog_wake;
    logic wdog_rst;
    logic clr_slp;
    logic clr_run;
    logic brn;
    logic por;
  } rsi_evt_t;

  typedef struct packed {
    logic [7:0] cictl;
    logic [7:0] pflg1;
    logic [7:0] pflg2;
  } rsi_wake_t;

endpackage : rsi_pkg

// ### core/rsi_sync.sv
/*
  Two-flop level synchroniser, one bit per lane.
  Assumes inputs are asynchronous to pclk; RST_VAL is the idle level.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // ****************************************
  // Synchroniser chain
  // ****************************************
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : rsi_sync
`default_nettype wire

// ### core/rsi_pat_reg.sv
/*
  One 8-bit register with per-category reset patterns.
  Assumes at most one category pulse per cycle; events beat writes.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_pat_reg #(
  parameter logic [7:0] IMPL    = 8'hff,
  parameter logic [7:0] POR_MSK = 8'hff,
  parameter logic [7:0] POR_VAL = 8'h00,
  parameter logic [7:0] CLR_MSK = 8'hff,
  parameter logic [7:0] CLR_VAL = 8'h00
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       por_evt,
  input  wire logic       clr_evt,
  input  wire logic       wake_evt,
  input  wire logic [7:0] wake_set,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value
);
  // ****************************************
  // Pattern register
  // ****************************************
  // Masked bits load, others hold; x bits load zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= POR_VAL & IMPL;
    end else if (por_evt) begin
      value <= ((value & ~POR_MSK) | (POR_VAL & POR_MSK)) & IMPL;
    end else if (clr_evt) begin
      value <= ((value & ~CLR_MSK) | (CLR_VAL & CLR_MSK)) & IMPL;
    end else if (wake_evt) begin
      value <= (value | wake_set) & IMPL;
    end else if (wr_en) begin
      value <= wr_data & IMPL;
    end
  end
endmodule : rsi_pat_reg
`default_nettype wire

// ### test/rsi_init_test.sv
/*
  Self-checking testbench of the reset state initializer, driven over APB
  and through the event pins and pulses.
  Assumes rsi_pkg and rsi_init compiled first; one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rsi_init_test;
  import rsi_pkg::*;

  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        por_req;
  logic        brownout_req;
  logic        clear_n;
  logic        watchdog_expire;
  logic        wake_irq;
  logic        core_sleeping;
  logic        instr_retire;
  rsi_wake_t   wake_src;
  logic [12:0] pc_in;
  logic [12:0] pc_value;
  logic        pc_load;
  logic [7:0]  core_status;
  logic [7:0]  core_int_ctrl;
  logic        irq;
  int          errors;
  int          n_compared;
  int          cycles;
  logic [31:0] rdat;
  logic        rerr;

  rsi_init u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_req(por_req), .brownout_req(brownout_req),
    .external_clear_pin_n(clear_n), .watchdog_expire(watchdog_expire),
    .wake_irq(wake_irq), .core_sleeping(core_sleeping), .instr_retire(instr_retire),
    .wake_src(wake_src), .pc_in(pc_in), .pc_value(pc_value), .pc_load(pc_load),
    .core_status(core_status), .core_int_ctrl(core_int_ctrl), .irq(irq)
  );

  // Free-running clock, 8 ns period
  always #4 pclk = ~pclk;

  // Hang guard: far above the fewer than two hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors = errors + 1;
      results();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(nm, exp, r);
    check("pslverr", 32'h0000_0000, {31'h0, e});
  endtask : rd_chk

  // Status seen both over APB and at the core port
  task automatic st_chk(input logic [7:0] exp);
    rd_chk("status", ADR_STATUS, {24'h0, exp});
    check("core_status", {24'h0, exp}, {24'h0, core_status});
  endtask : st_chk

  // Bounded wait for the PC load pulse, then its value
  task automatic wait_load(input logic [12:0] exp_pc);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pc_load !== 1'b1 && n < 20);
    check("pc_load", 32'h0000_0001, {31'h0, pc_load});
    check("pc_value", {19'h0, exp_pc}, {19'h0, pc_value});
  endtask : wait_load

  // Same-clock pulses: 0 watchdog, 1 wake interrupt, 2 retire
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: watchdog_expire <= 1'b1;
      1: wake_irq <= 1'b1;
      default: instr_retire <= 1'b1;
    endcase
    @(posedge pclk);
    watchdog_expire <= 1'b0;
    wake_irq        <= 1'b0;
    instr_retire    <= 1'b0;
  endtask : pulse

  // Asynchronous pins: 0 power-on, 1 brown-out, 2 clear; released after the load
  task automatic pin_evt(input int k);
    @(posedge pclk);
    case (k)
      0: por_req <= 1'b1;
      1: brownout_req <= 1'b1;
      default: clear_n <= 1'b0;
    endcase
    wait_load(13'h0000);
    @(posedge pclk);
    por_req <= 1'b0;
    brownout_req <= 1'b0;
    clear_n <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask : pin_evt

  task automatic chk_irq(input logic exp);
    @(posedge pclk);
    check("irq", {31'h0, exp}, {31'h0, irq});
  endtask : chk_irq

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {por_req, brownout_req, watchdog_expire, wake_irq, core_sleeping, instr_retire} = '0;
    clear_n = 1'b1;
    wake_src = '0;
    pc_in = 13'h0000;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    st_chk(8'h18);
    rd_chk("rcf", ADR_RCF, 32'h0000_0000);
    wr(ADR_RCF, 32'h0000_0003);
    wr(ADR_STATUS, 32'h0000_00e7);
    st_chk(8'hff);
    $display("test reset_values done");
    pin_evt(2);
    st_chk(8'h1f);
    rd_chk("rcf", ADR_RCF, 32'h0000_0003);
    pulse(0);
    wait_load(13'h0000);
    st_chk(8'h0f);
    rd_chk("rcf", ADR_RCF, 32'h0000_0003);
    $display("test running_resets done");
    core_sleeping <= 1'b1;
    pin_evt(2);
    st_chk(8'h17);
    pc_in <= 13'h0123;
    pulse(0);
    wait_load(13'h0124);
    st_chk(8'h07);
    $display("test sleep_resets done");
    wr(ADR_CICTL, 32'h0000_0080);
    wr(ADR_EVMSK, 32'h0000_0040);
    chk_irq(1'b0);
    pc_in <= 13'h0456;
    wake_src <= {8'h04, 8'h01, 8'hff};
    pulse(1);
    wait_load(13'h0457);
    st_chk(8'h17);
    rd_chk("cictl", ADR_CICTL, 32'h0000_0084);
    check("core_int_ctrl", 32'h0000_0084, {24'h0, core_int_ctrl});
    rd_chk("pflg1", ADR_PFLG1, 32'h0000_0001);
    rd_chk("pflg2", ADR_PFLG2, 32'h0000_0001);
    pulse(2);
    wait_load(13'h0004);
    $display("test wake_vector done");
    chk_irq(1'b1);
    rd_chk("evst", ADR_EVST, 32'h0000_007c);
    wr(ADR_EVMSK, 32'h0000_0000);
    chk_irq(1'b0);
    wr(ADR_EVMSK, 32'h0000_0040);
    chk_irq(1'b1);
    wr(ADR_EVST, 32'h0000_007f);
    chk_irq(1'b0);
    rd_chk("evst", ADR_EVST, 32'h0000_0000);
    $display("test interrupt done");
    core_sleeping <= 1'b0;
    pulse(1);
    repeat (3) begin
      @(posedge pclk);
      check("pc_load", 32'h0000_0000, {31'h0, pc_load});
    end
    pin_evt(1);
    rd_chk("rcf", ADR_RCF, 32'h0000_0002);
    st_chk(8'h1f);
    rd_chk("cictl", ADR_CICTL, 32'h0000_0000);
    check("core_int_ctrl", 32'h0000_0000, {24'h0, core_int_ctrl});
    rd_chk("pflg1", ADR_PFLG1, 32'h0000_0000);
    rd_chk("pflg2", ADR_PFLG2, 32'h0000_0000);
    wr(ADR_RCF, 32'h0000_00ff);
    rd_chk("rcf", ADR_RCF, 32'h0000_0003);
    pin_evt(0);
    rd_chk("rcf", ADR_RCF, 32'h0000_0001);
    st_chk(8'h1f);
    rd_chk("pc_read", ADR_PCRD, 32'h0000_0000);
    $display("test power_resets done");
    apb(1'b0, 12'h200, 32'h0000_0000, rdat, rerr);
    check("pslverr", 32'h0000_0001, {31'h0, rerr});
    $display("test unmapped done");
    results();
  end
endmodule : rsi_init_test
`default_nettype wire
